// *** hw/sslm_top.sv ***
// Safe speed limit monitor: level select, setpoint clamp, ramp supervision, AXI4-Lite registers
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`include "sslm_regs.svh"
module sslm_top
  import sslm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic limit_select,
  input wire logic [1:0] level_index,
  input wire logic signed [15:0] speed_setpoint,
  input wire logic signed [15:0] speed_actual,
  output logic signed [15:0] speed_setpoint_out,
  output logic quick_stop_ramp,
  output logic stop_a,
  output logic stop_b,
  output logic limiting_active_flag,
  output logic speed_below_limit,
  output logic irq
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic en;
    logic hys_en;
    logic acc_req;
    logic [1:0] fspec;
    logic [3:0][15:0] lvl;
    logic [7:0] pct;
    logic [15:0] chg_ms;
    logic [3:0] stop_resp;
    logic [15:0] rref;
    logic [15:0] rdly_ms;
    logic [15:0] rtime_ms;
    logic [15:0] dir_max_pos;
    logic [15:0] dir_max_neg;
    logic [16:0] acc_ms;
    logic [15:0] fb_lim;
    logic [15:0] fb_hys;
    logic [15:0] fb_filt;
    sslm_lim_e st;
    logic accept;
    logic [15:0] ramp_lim;
    logic [15:0] ramp_start;
    logic [15:0] lvl_lim;
    logic [15:0] clamp;
    logic [15:0] sp_out;
    logic qs;
    logic stop_a;
    logic stop_b;
    logic active;
    logic [2:0] irq_st;
    logic [2:0] irq_en;
    logic irq;
    logic [17:0] ms_div;
    logic tick;
    logic [1:0] sel_s1;
    logic sel_s2;
    logic [1:0] idx_s1;
    logic [1:0] idx_s2;
  } sslm_state_s;

  sslm_state_s q_r;
  sslm_state_s q_nxt;

  // ------------------------------------------------------------
  // Timers and feedback monitor
  // ------------------------------------------------------------
  logic chg_exp;
  logic rdly_exp;
  logic acc_exp;
  logic acc_start;
  logic [16:0] rdly_el;
  logic below;
  logic [15:0] abs_act;

  assign abs_act = speed_actual[15] ? 16'(-speed_actual) : speed_actual;
  assign acc_start = q_r.acc_req && !q_r.accept;

  // Change and ramp timers reload while idle, so every entry starts fresh even without a new select edge
  sslm_ms_timer u_chg (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick_ms(q_r.tick),
    .load(q_r.st == SSLM_IDLE),
    .load_val({1'b0, q_r.chg_ms}),
    .run(q_r.st == SSLM_CHANGE),
    .expired(chg_exp),
    .elapsed()
  );

  sslm_ms_timer u_rdly (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick_ms(q_r.tick),
    .load(q_r.st == SSLM_IDLE),
    .load_val(17'(q_r.rdly_ms) + 17'(q_r.rtime_ms)),
    .run(q_r.st != SSLM_IDLE),
    .expired(rdly_exp),
    .elapsed(rdly_el)
  );

  sslm_ms_timer u_acc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick_ms(q_r.tick),
    .load(acc_start),
    .load_val(q_r.acc_ms),
    .run(q_r.accept),
    .expired(acc_exp),
    .elapsed()
  );

  sslm_feedback u_fb (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick_ms(q_r.tick),
    .abs_speed(abs_act),
    .limit(q_r.fb_lim),
    .hyst(q_r.fb_hys),
    .filt_ms(q_r.fb_filt),
    .hys_en(q_r.hys_en),
    .below(below)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [31:0] wmask;
  logic [31:0] wv;
  logic [31:0] rd;
  logic [23:0] prod;
  logic [15:0] env;
  logic [31:0] slope;
  logic [15:0] lim_sel;
  logic viol;
  logic do_wr;

  always_comb begin
    q_nxt = q_r;
    aw_hs = s_axi_awvalid && !q_r.aw_got;
    w_hs = s_axi_wvalid && !q_r.w_got;
    ar_hs = s_axi_arvalid && !q_r.rvalid;
    wmask = {{8{q_r.wstrb[3]}}, {8{q_r.wstrb[2]}}, {8{q_r.wstrb[1]}}, {8{q_r.wstrb[0]}}};
    wv = q_r.wdata & wmask;
    do_wr = q_r.aw_got && q_r.w_got && !q_r.bvalid;
    rd = 32'h00000000;
    prod = 24'h000000;
    env = 16'h0000;
    slope = 32'h00000000;
    lim_sel = q_r.lvl[q_r.idx_s2];
    viol = 1'b0;

    // Pin synchronisers and millisecond tick
    q_nxt.sel_s1 = {q_r.sel_s1[0], limit_select};
    q_nxt.sel_s2 = q_r.sel_s1[1];
    q_nxt.idx_s1 = level_index;
    q_nxt.idx_s2 = q_r.idx_s1;
    q_nxt.tick = 1'b0;
    if (q_r.ms_div == 18'(`SSLM_MS_CYC - 1)) begin
      q_nxt.ms_div = 18'h00000;
      q_nxt.tick = 1'b1;
    end else begin
      q_nxt.ms_div = q_r.ms_div + 18'h00001;
    end

    // Limiting state machine
    unique case (q_r.st)
      SSLM_IDLE: begin
        if (q_r.en && q_r.sel_s2) q_nxt.st = SSLM_CHANGE;
      end
      SSLM_CHANGE: begin
        // Ramp mode: braking phase ends once the speed is at or under the level
        if (!q_r.en || !q_r.sel_s2) begin
          q_nxt.st = SSLM_IDLE;
        end else if (q_r.fspec == `SSLM_FSPEC_NORAMP) begin
          if (chg_exp) q_nxt.st = SSLM_ACTIVE;
        end else if (abs_act <= lim_sel) begin
          q_nxt.st = SSLM_ACTIVE;
        end
      end
      SSLM_ACTIVE: begin
        if (!q_r.en || !q_r.sel_s2) q_nxt.st = SSLM_IDLE;
      end
      default: q_nxt.st = SSLM_IDLE;
    endcase
    q_nxt.active = (q_nxt.st == SSLM_ACTIVE);
    q_nxt.qs = (q_nxt.st != SSLM_IDLE) && (abs_act > q_r.clamp);

    // Setpoint clamp
    prod = 24'(lim_sel) * 24'(q_r.pct);
    q_nxt.lvl_lim = lim_sel;
    q_nxt.clamp = 16'(prod / 24'd100);
    if (q_r.st == SSLM_IDLE) q_nxt.ramp_start = abs_act;
    slope = (32'(q_r.rref) * 32'(rdly_el > 17'(q_r.rdly_ms) ?
             rdly_el - 17'(q_r.rdly_ms) : 17'h00000)) / 32'(q_r.rtime_ms | 16'h0001);
    if (rdly_el <= 17'(q_r.rdly_ms)) begin
      env = 16'hffff;
    end else if (32'(q_r.ramp_start) > slope) begin
      env = 16'(32'(q_r.ramp_start) - slope);
    end else begin
      env = 16'h0000;
    end
    if (rdly_exp && rdly_el != 17'h00000) env = 16'h0000;
    q_nxt.ramp_lim = (q_r.fspec == `SSLM_FSPEC_RAMP && q_r.st != SSLM_IDLE) ? env : 16'h0000;

    q_nxt.sp_out = speed_setpoint;
    if (speed_setpoint > $signed(q_r.dir_max_pos)) q_nxt.sp_out = q_r.dir_max_pos;
    if (speed_setpoint < -$signed(q_r.dir_max_neg)) begin
      q_nxt.sp_out = 16'(-$signed(q_r.dir_max_neg));
    end
    if (q_r.st != SSLM_IDLE && !q_r.accept) begin
      if (speed_setpoint > $signed(q_r.clamp)) q_nxt.sp_out = q_r.clamp;
      if (speed_setpoint < -$signed(q_r.clamp)) q_nxt.sp_out = 16'(-$signed(q_r.clamp));
    end

    // Violation and stop response
    if (q_r.active && abs_act > lim_sel) viol = 1'b1;
    if (q_r.fspec == `SSLM_FSPEC_RAMP && q_r.st != SSLM_IDLE && abs_act > env) viol = 1'b1;
    if (q_r.accept) viol = 1'b0;
    if (viol) begin
      if (q_r.stop_resp[q_r.idx_s2]) q_nxt.stop_b = 1'b1;
      else q_nxt.stop_a = 1'b1;
    end

    // Acceptance mode
    q_nxt.acc_req = 1'b0;
    if (acc_start) q_nxt.accept = 1'b1;
    else if (q_r.accept && acc_exp) q_nxt.accept = 1'b0;

    // AXI4-Lite slave
    if (aw_hs) begin
      q_nxt.aw_got = 1'b1;
      q_nxt.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      q_nxt.w_got = 1'b1;
      q_nxt.wdata = s_axi_wdata;
      q_nxt.wstrb = s_axi_wstrb;
    end
    if (do_wr) begin
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = 2'b00;
      unique case (q_r.awaddr)
        `SSLM_CTRL_OFS: begin
          q_nxt.en = wv[`SSLM_CTRL_EN_BIT];
          q_nxt.hys_en = wv[`SSLM_CTRL_HYS_BIT];
          q_nxt.acc_req = wv[`SSLM_CTRL_ACC_BIT];
        end
        `SSLM_FSPEC_OFS: q_nxt.fspec = wv[1:0];
        `SSLM_LVL0_OFS: q_nxt.lvl[0] = wv[15:0];
        `SSLM_LVL1_OFS: q_nxt.lvl[1] = wv[15:0];
        `SSLM_LVL2_OFS: q_nxt.lvl[2] = wv[15:0];
        `SSLM_LVL3_OFS: q_nxt.lvl[3] = wv[15:0];
        `SSLM_PCT_OFS: q_nxt.pct = wv[7:0];
        `SSLM_CHG_OFS: q_nxt.chg_ms = wv[15:0];
        `SSLM_STOPR_OFS: q_nxt.stop_resp = wv[3:0];
        `SSLM_RREF_OFS: q_nxt.rref = wv[15:0];
        `SSLM_RDLY_OFS: q_nxt.rdly_ms = wv[15:0];
        `SSLM_RTIME_OFS: q_nxt.rtime_ms = wv[15:0];
        `SSLM_RFGP_OFS: q_nxt.dir_max_pos = wv[15:0];
        `SSLM_RFGN_OFS: q_nxt.dir_max_neg = wv[15:0];
        `SSLM_ACC_OFS: begin
          q_nxt.acc_ms = (wv > 32'(`SSLM_ACC_MS_MAX)) ? `SSLM_ACC_MS_MAX : wv[16:0];
        end
        `SSLM_FBLIM_OFS: q_nxt.fb_lim = wv[15:0];
        `SSLM_FBHYS_OFS: q_nxt.fb_hys = wv[15:0];
        `SSLM_FBFILT_OFS: q_nxt.fb_filt = wv[15:0];
        `SSLM_STAT_OFS: q_nxt.stop_a = q_r.stop_a;
        `SSLM_IRQEN_OFS: q_nxt.irq_en = wv[2:0];
        `SSLM_IRQCLR_OFS: begin
          q_nxt.irq_st = q_r.irq_st & ~wv[2:0];
          // Writing the stop bits in the clear register also releases the stops
          if (wv[3]) q_nxt.stop_a = 1'b0;
          if (wv[4]) q_nxt.stop_b = 1'b0;
        end
        default: q_nxt.bresp = 2'b10;
      endcase
    end
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got = 1'b0;
    end

    // Events set after clears so a coincident event is kept
    if (viol) q_nxt.irq_st[`SSLM_IRQ_VIOL_BIT] = 1'b1;
    if (viol && q_r.stop_resp[q_r.idx_s2]) q_nxt.stop_b = 1'b1;
    if (viol && !q_r.stop_resp[q_r.idx_s2]) q_nxt.stop_a = 1'b1;
    if (q_r.accept && acc_exp) q_nxt.irq_st[`SSLM_IRQ_ACCEND_BIT] = 1'b1;
    if (q_nxt.active && !q_r.active) q_nxt.irq_st[`SSLM_IRQ_ACTIVE_BIT] = 1'b1;
    q_nxt.irq = |(q_nxt.irq_st & q_nxt.irq_en);

    if (ar_hs) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = 2'b00;
      unique case (s_axi_araddr)
        `SSLM_CTRL_OFS: rd = {29'h0, q_r.acc_req, q_r.hys_en, q_r.en};
        `SSLM_FSPEC_OFS: rd = {30'h0, q_r.fspec};
        `SSLM_LVL0_OFS: rd = {16'h0, q_r.lvl[0]};
        `SSLM_LVL1_OFS: rd = {16'h0, q_r.lvl[1]};
        `SSLM_LVL2_OFS: rd = {16'h0, q_r.lvl[2]};
        `SSLM_LVL3_OFS: rd = {16'h0, q_r.lvl[3]};
        `SSLM_PCT_OFS: rd = {24'h0, q_r.pct};
        `SSLM_CHG_OFS: rd = {16'h0, q_r.chg_ms};
        `SSLM_STOPR_OFS: rd = {28'h0, q_r.stop_resp};
        `SSLM_RREF_OFS: rd = {16'h0, q_r.rref};
        `SSLM_RDLY_OFS: rd = {16'h0, q_r.rdly_ms};
        `SSLM_RTIME_OFS: rd = {16'h0, q_r.rtime_ms};
        `SSLM_RFGP_OFS: rd = {16'h0, q_r.dir_max_pos};
        `SSLM_RFGN_OFS: rd = {16'h0, q_r.dir_max_neg};
        `SSLM_ACC_OFS: rd = {15'h0, q_r.acc_ms};
        `SSLM_FBLIM_OFS: rd = {16'h0, q_r.fb_lim};
        `SSLM_FBHYS_OFS: rd = {16'h0, q_r.fb_hys};
        `SSLM_FBFILT_OFS: rd = {16'h0, q_r.fb_filt};
        `SSLM_STAT_OFS: rd = {27'h0, q_r.stop_b, q_r.stop_a, q_r.accept, below, q_r.active};
        `SSLM_DIAG0_OFS: rd = {{16{speed_actual[15]}}, speed_actual};
        `SSLM_DIAG1_OFS: rd = {16'h0, q_r.ramp_lim};
        `SSLM_DIAG2_OFS: rd = {16'h0, q_r.lvl_lim};
        `SSLM_CLMP0_OFS: rd = {16'h0, q_r.clamp};
        `SSLM_CLMP1_OFS: rd = 32'(-$signed({16'h0, q_r.clamp}));
        `SSLM_CLMP2_OFS: rd = {16'h0, q_r.clamp};
        `SSLM_IRQST_OFS: rd = {29'h0, q_r.irq_st};
        `SSLM_IRQEN_OFS: rd = {29'h0, q_r.irq_en};
        `SSLM_IRQCLR_OFS: rd = 32'h00000000;
        default: q_nxt.rresp = 2'b10;
      endcase
      q_nxt.rdata = rd;
    end
    if (q_r.rvalid && s_axi_rready) q_nxt.rvalid = 1'b0;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q_r <= '0;
      q_r.fspec <= `SSLM_FSPEC_RST;
      q_r.lvl <= {4{`SSLM_LVL_RST}};
      q_r.pct <= `SSLM_PCT_RST;
      q_r.chg_ms <= `SSLM_CHG_MS_RST;
      q_r.rref <= `SSLM_RREF_RST;
      q_r.rdly_ms <= `SSLM_RDLY_MS_RST;
      q_r.rtime_ms <= `SSLM_RTIME_MS_RST;
      q_r.dir_max_pos <= `SSLM_DIRMAX_RST;
      q_r.dir_max_neg <= `SSLM_DIRMAX_RST;
      q_r.acc_ms <= `SSLM_ACC_MS_RST;
      q_r.fb_lim <= `SSLM_FBLIM_RST;
      q_r.fb_hys <= `SSLM_FBHYS_RST;
      q_r.fb_filt <= `SSLM_FBFILT_RST;
      q_r.st <= SSLM_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  logic below_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) below_r <= 1'b0;
    else below_r <= below;
  end

  assign s_axi_awready = 1'b1 && !q_r.aw_got;
  assign s_axi_wready = !q_r.w_got;
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp = q_r.bresp;
  assign s_axi_arready = !q_r.rvalid;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rdata = q_r.rdata;
  assign s_axi_rresp = q_r.rresp;
  assign speed_setpoint_out = q_r.sp_out;
  assign quick_stop_ramp = q_r.qs;
  assign stop_a = q_r.stop_a;
  assign stop_b = q_r.stop_b;
  assign limiting_active_flag = q_r.active;
  assign speed_below_limit = below_r;
  assign irq = q_r.irq;
endmodule : sslm_top

// *** hw/sslm_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the speed limit monitor
`ifndef SSLM_REGS_SVH
`define SSLM_REGS_SVH

// Register byte addresses
`define SSLM_CTRL_OFS 8'h00
`define SSLM_FSPEC_OFS 8'h04
`define SSLM_LVL0_OFS 8'h08
`define SSLM_LVL1_OFS 8'h0c
`define SSLM_LVL2_OFS 8'h10
`define SSLM_LVL3_OFS 8'h14
`define SSLM_PCT_OFS 8'h18
`define SSLM_CHG_OFS 8'h1c
`define SSLM_STOPR_OFS 8'h20
`define SSLM_RREF_OFS 8'h24
`define SSLM_RDLY_OFS 8'h28
`define SSLM_RTIME_OFS 8'h2c
`define SSLM_RFGP_OFS 8'h30
`define SSLM_RFGN_OFS 8'h34
`define SSLM_ACC_OFS 8'h38
`define SSLM_FBLIM_OFS 8'h3c
`define SSLM_FBHYS_OFS 8'h40
`define SSLM_FBFILT_OFS 8'h44
`define SSLM_STAT_OFS 8'h48
`define SSLM_DIAG0_OFS 8'h4c
`define SSLM_DIAG1_OFS 8'h50
`define SSLM_DIAG2_OFS 8'h54
`define SSLM_CLMP0_OFS 8'h58
`define SSLM_CLMP1_OFS 8'h5c
`define SSLM_CLMP2_OFS 8'h60
`define SSLM_IRQST_OFS 8'h64
`define SSLM_IRQEN_OFS 8'h68
`define SSLM_IRQCLR_OFS 8'h6c

// Control register fields
`define SSLM_CTRL_EN_BIT 0
`define SSLM_CTRL_HYS_BIT 1
`define SSLM_CTRL_ACC_BIT 2

// Status register fields
`define SSLM_ST_ACTIVE_BIT 0
`define SSLM_ST_BELOW_BIT 1
`define SSLM_ST_ACCEPT_BIT 2
`define SSLM_ST_STOPA_BIT 3
`define SSLM_ST_STOPB_BIT 4

// Interrupt status fields
`define SSLM_IRQ_VIOL_BIT 0
`define SSLM_IRQ_ACCEND_BIT 1
`define SSLM_IRQ_ACTIVE_BIT 2

// Reset values
`define SSLM_FSPEC_RST 2'd1
`define SSLM_LVL_RST 16'd2000
`define SSLM_PCT_RST 8'd80
`define SSLM_CHG_MS_RST 16'd100
`define SSLM_RREF_RST 16'd1500
`define SSLM_RDLY_MS_RST 16'd250
`define SSLM_RTIME_MS_RST 16'd10000
`define SSLM_DIRMAX_RST 16'd3000
`define SSLM_ACC_MS_RST 17'd40000
`define SSLM_ACC_MS_MAX 17'd100000
`define SSLM_FBLIM_RST 16'd20
`define SSLM_FBHYS_RST 16'd10
`define SSLM_FBFILT_RST 16'd0

// Function specification codes
`define SSLM_FSPEC_RAMP 2'd1
`define SSLM_FSPEC_NORAMP 2'd3

// Millisecond tick at 200 MHz
`define SSLM_CLK_HZ 200000000
`define SSLM_MS_CYC (`SSLM_CLK_HZ / 1000)

`endif

// *** hw/sslm_pkg.sv ***
// Types of the speed limit monitor
package sslm_pkg;
  typedef enum logic [1:0] {
    SSLM_IDLE = 2'b00,
    SSLM_CHANGE = 2'b01,
    SSLM_ACTIVE = 2'b10
  } sslm_lim_e;

  typedef logic signed [15:0] sslm_speed_t;
endpackage : sslm_pkg

// *** hw/sslm_ms_timer.sv ***
// Millisecond down-counter with load, runs on a shared tick
module sslm_ms_timer (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tick_ms,
  input wire logic load,
  input wire logic [16:0] load_val,
  input wire logic run,
  output logic expired,
  output logic [16:0] elapsed
);
  logic [16:0] remain_r;
  logic [16:0] start_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      remain_r <= 17'h00000;
      start_r <= 17'h00000;
    end else if (load) begin
      remain_r <= load_val;
      start_r <= load_val;
    end else if (run && tick_ms && remain_r != 17'h00000) begin
      remain_r <= remain_r - 17'h00001;
    end
  end

  assign expired = (remain_r == 17'h00000);
  assign elapsed = start_r - remain_r;
endmodule : sslm_ms_timer

// *** hw/sslm_feedback.sv ***
// Safe speed feedback monitor: below-limit flag with optional hysteresis and filter
module sslm_feedback (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tick_ms,
  input wire logic [15:0] abs_speed,
  input wire logic [15:0] limit,
  input wire logic [15:0] hyst,
  input wire logic [15:0] filt_ms,
  input wire logic hys_en,
  output logic below
);
  logic [15:0] filt_r;
  logic [15:0] cnt_r;
  logic below_r;
  logic [15:0] spd;
  logic [16:0] upper;

  // Filter: first-order step toward sample once per filter period
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      filt_r <= 16'h0000;
      cnt_r <= 16'h0000;
    end else if (!hys_en || filt_ms == 16'h0000) begin
      filt_r <= abs_speed;
      cnt_r <= 16'h0000;
    end else if (tick_ms) begin
      if (cnt_r >= filt_ms - 16'h0001) begin
        cnt_r <= 16'h0000;
        filt_r <= filt_r + 16'((17'(abs_speed) - 17'(filt_r)) >>> 1);
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  assign spd = hys_en ? filt_r : abs_speed;
  assign upper = 17'(limit) + 17'(hyst);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      below_r <= 1'b0;
    end else if (!hys_en) begin
      below_r <= (abs_speed < limit);
    end else if (spd < limit) begin
      below_r <= 1'b1;
    end else if (17'(spd) >= upper) begin
      below_r <= 1'b0;
    end
  end

  assign below = below_r;
endmodule : sslm_feedback

// *** tb/sslm_motor.sv ***
// Motor speed controller and safety command source model
module sslm_motor (
  input wire logic clk_sys,
  input wire logic sel_cmd,
  input wire logic [1:0] lvl_cmd,
  input wire logic signed [15:0] sp_cmd,
  input wire logic frc_en,
  input wire logic signed [15:0] frc_val,
  input wire logic signed [15:0] speed_setpoint_out,
  output logic limit_select,
  output logic [1:0] level_index,
  output logic signed [15:0] speed_setpoint,
  output logic signed [15:0] speed_actual
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    limit_select = 1'b0;
    level_index = 2'h0;
    speed_setpoint = 16'h0000;
    speed_actual = 16'h0000;
  end
  // Motor follows the clamped setpoint unless a speed value is forced
  always @(posedge clk_sys) begin
    level_index <= lvl_cmd;
    if (level_index == lvl_cmd) limit_select <= sel_cmd;
    speed_setpoint <= sp_cmd;
    speed_actual <= frc_en ? frc_val : speed_setpoint_out;
  end
endmodule : sslm_motor

// *** tb/sslm_chk.sv ***
// Port checker of the speed limit monitor, bound to its top
module sslm_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic limit_select,
  input wire logic signed [15:0] speed_setpoint,
  input wire logic signed [15:0] speed_actual,
  input wire logic signed [15:0] speed_setpoint_out,
  input wire logic quick_stop_ramp,
  input wire logic stop_a,
  input wire logic stop_b,
  input wire logic limiting_active_flag,
  input wire logic speed_below_limit,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ----
  // Bus answers
  // ----
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_RESP_CODE: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response");
  AST_RD_REFUSE: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("refused read not clean");
  // ----
  // Speed supervision
  // ----
  AST_QSR_IDLE: assert property (!limit_select [*5] |-> !quick_stop_ramp)
    else $error("braking without selection");
  AST_FLAG_IDLE: assert property ((!limit_select) [*5] |-> !limiting_active_flag)
    else $error("active flag without selection");
  AST_SETPOINT_PASS: assert property ((!limit_select && $stable(speed_setpoint)) [*8] |->
    speed_setpoint_out == speed_setpoint || speed_setpoint > 16'sh0bb8 ||
    speed_setpoint < -16'sh0bb8) else $error("setpoint altered inside limits");
  AST_BELOW_SPEED: assert property ($stable(speed_actual) [*6] |->
    speed_below_limit == (speed_actual < 16'sh0014 && speed_actual > -16'sh0014))
    else $error("below flag wrong");
  AST_STOP_CAUSE: assert property ($rose(stop_a) || $rose(stop_b) |->
    limiting_active_flag || $past(limiting_active_flag)) else $error("stop without active");
  AST_STOP_CLEAR: assert property ($fell(stop_a) || $fell(stop_b) |-> ##[0:1] s_axi_bvalid)
    else $error("stop cleared without write");
  cover property ($rose(limiting_active_flag));
  cover property ($rose(stop_b));
  cover property ($fell(irq));
endmodule : sslm_chk

bind sslm_top sslm_chk u_chk (.clk_sys, .sys_rst, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .limit_select, .speed_setpoint,
  .speed_actual, .speed_setpoint_out, .quick_stop_ramp, .stop_a, .stop_b,
  .limiting_active_flag, .speed_below_limit, .irq);

// *** tb/tb_top.sv ***
// Self-checking bench of the speed limit monitor
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic sel_cmd = 1'b0, frc_en = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, level_index, lvl_cmd = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, limit_select;
  logic quick_stop_ramp, stop_a, stop_b, limiting_active_flag, speed_below_limit, irq;
  logic signed [15:0] speed_setpoint, speed_actual, speed_setpoint_out;
  logic signed [15:0] sp_cmd = 16'h0000, frc_val = 16'h0000;
  int fails = 0, check_count = 0, cycles = 0;
  // Offsets and expected values: reset table, then clamps and diagnostics
  logic [7:0] ra [18] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
    8'h28, 8'h2c, 8'h38, 8'h3c, 8'h58, 8'h5c, 8'h60, 8'h4c, 8'h54};
  logic [15:0] rv [18] = '{16'h0001, 16'h07d0, 16'h07d0, 16'h07d0, 16'h07d0, 16'h0050,
    16'h0064, 16'h0000, 16'h05dc, 16'h00fa, 16'h2710, 16'h9c40, 16'h0014, 16'h0320,
    16'hfce0, 16'h0320, 16'h0320, 16'h03e8};

  sslm_top DUT (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .limit_select, .level_index, .speed_setpoint, .speed_actual,
    .speed_setpoint_out, .quick_stop_ramp, .stop_a, .stop_b, .limiting_active_flag,
    .speed_below_limit, .irq);
  sslm_motor m_motor (.clk_sys, .sel_cmd, .lvl_cmd, .sp_cmd, .frc_en, .frc_val,
    .speed_setpoint_out, .limit_select, .level_index, .speed_setpoint, .speed_actual);

  // ----
  // Access tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    cyc(3);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  task automatic rtab(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      rd(ra[i]);
      chk(d[15:0], rv[i]);
    end
  endtask : rtab
  task automatic wrap_up();
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  // ----
  // Test sequence
  // ----
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cyc(8);
    chk(16'(speed_below_limit), 16'h1);
    frc_en <= 1'b1;
    frc_val <= 16'h0014;
    cyc(8);
    chk(16'(speed_below_limit), 16'h0);
    frc_val <= 16'hffed;
    cyc(8);
    chk(16'(speed_below_limit), 16'h1);
    frc_en <= 1'b0;
    rtab(0, 12);
    rd(8'hfc);
    chk(16'(rsp), 16'h2);
    wr(8'hf0, 32'h1);
    chk(16'(rsp), 16'h2);
    wr(8'h38, 32'h00030d40);
    rd(8'h38);
    chk(d[31:16], 16'h0001);
    chk(d[15:0], 16'h86a0);
    wr(8'h0c, 32'h3e8);
    wr(8'h68, 32'h7);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h3);
    sp_cmd <= 16'h07d0;
    frc_en <= 1'b1;
    frc_val <= 16'h07d0;
    lvl_cmd <= 2'h1;
    sel_cmd <= 1'b1;
    cyc(20);
    chk(16'(limiting_active_flag), 16'h0);
    chk(16'(quick_stop_ramp), 16'h1);
    chk(speed_setpoint_out, 16'h0320);
    frc_en <= 1'b0;
    sel_cmd <= 1'b0;
    wr(8'h04, 32'h1);
    sel_cmd <= 1'b1;
    cyc(12);
    chk(16'(limiting_active_flag), 16'h1);
    chk(speed_setpoint_out, 16'h0320);
    rtab(13, 17);
    rd(8'h50);
    chk(d[15:0], 16'hffff);
    chk(16'(irq), 16'h1);
    wr(8'h6c, 32'h4);
    chk(16'(irq), 16'h0);
    frc_en <= 1'b1;
    frc_val <= 16'h04b0;
    cyc(6);
    chk(16'(stop_a), 16'h1);
    chk(16'(irq), 16'h1);
    wr(8'h68, 32'h0);
    chk(16'(irq), 16'h0);
    frc_en <= 1'b0;
    wr(8'h68, 32'h7);
    wr(8'h6c, 32'h9);
    chk(16'({stop_a, irq}), 16'h0);
    wr(8'h20, 32'h2);
    frc_en <= 1'b1;
    cyc(6);
    chk(16'({stop_a, stop_b}), 16'h1);
    frc_en <= 1'b0;
    cyc(4);
    wr(8'h6c, 32'h13);
    wr(8'h00, 32'h0);
    cyc(4);
    chk(16'(limiting_active_flag), 16'h0);
    chk(speed_setpoint_out, 16'h07d0);
    wr(8'h00, 32'h5);
    rd(8'h48);
    chk(16'(d[2]), 16'h1);
    frc_en <= 1'b1;
    cyc(6);
    chk(16'({stop_a, stop_b}), 16'h0);
    frc_en <= 1'b0;
    sel_cmd <= 1'b0;
    sp_cmd <= 16'h0fa0;
    cyc(10);
    chk(speed_setpoint_out, 16'h0bb8);
    sp_cmd <= 16'hf060;
    cyc(10);
    chk(speed_setpoint_out, 16'hf448);
    wrap_up();
  end
endmodule : tb_top
